/* File: inc/clk_ctrl_defs.svh */
// Register offsets, field positions, status bit positions and timing counts
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH
`define OFS_MAIN_OSC    8'h00
`define OFS_MAIN_FREQ   8'h04
`define OFS_PLL_A       8'h08
`define OFS_USB_PLL     8'h0c
`define OFS_MASTER_CLK  8'h10
`define OFS_STATUS      8'h14
`define OFS_INT_MASK    8'h18
`define OFS_FAST_WAKE   8'h1c
`define OFS_MAIN_OSC_ST 8'h20
// main_osc_reg fields
`define MOR_SEL_BIT     0
`define MOR_RCF_LSB     1
// main_freq_reg fields
`define MCFR_RDY_BIT    16
// pll_a_reg fields
`define PLL_DIV_LSB     0
`define PLL_CNT_LSB     8
`define PLL_MUL_LSB     16
// master_clock_reg fields
`define MCK_CSS_LSB     0
`define MCK_MASTER_SCALER_LSB    4
`define MCK_HALF_BIT    12
// status / mask bit positions
`define ST_SWITCH_DONE  0
`define ST_PLL_A        1
`define ST_USB_PLL      2
`define ST_MCK          3
`define ST_FREQ_RDY     4
`define ST_RC_STABLE    5
`define ST_XT_STABLE    6
`define ST_SLEEP        7
// Frequency gate length in slow falls counted after the opening slow rise
`define FREQ_GATE_PER   5'd16
`define USB_SLOW_DIV    3'd7
`define MASTER_SCALER_DIV3       3'd7
`endif

/* File: inc/clk_ctrl_pkg.sv */
// Types shared by the clock controller
package clk_ctrl_pkg;
  typedef enum logic [1:0] {
    SRC_SLOW, SRC_MAIN, SRC_PLL_A, SRC_USB
  } master_src_t;
  typedef enum {FC_IDLE, FC_ARM, FC_RUN, FC_DONE} freq_state_t;
endpackage : clk_ctrl_pkg

/* File: core/main_pll_master_clock_ctrl.sv */
// Clock generation and master clock control core
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "clk_ctrl_defs.svh"
// Summary of operation
// - Glitch-free main source switch on select bit
// - Switch-done flag, may raise interrupt
// - Fast RC default and forced in Wait
// - Counter restarts after slow rise on events
// - Sixteenth slow fall stops counter, sets ready
// - Count field holds main cycles per window
// - Divider 1..255; zero holds outputs low
// - Divider ratio resets to zero
// - PLL output equals source times (mul+1)/div
// - Zero feedback factor disables the PLL
// - PLL settle count reload, slow decrement
// - Half-select divides PLL clock by two
// - USB PLL settle count at slow/8
// - Master source select, prescale 1..64 or 3
// - Master clock write clears settled flag
// - Wait instruction with low power zero sleeps
// - Processor clock woken by interrupt or reset
// - Instruction completes; bus keeps being served
module main_pll_master_clock_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Oscillator and clock levels from outside the domain
  input  wire logic        slow_clock_signal,
  input  wire logic        main_clock_signal,
  input  wire logic        fast_rc_stable,
  input  wire logic        crystal_stable,
  input  wire logic        wait_mode,
  // Processor handshake
  input  wire logic        wait_instr,
  input  wire logic        instr_done,
  input  wire logic        wake_irq,
  // Generated controls
  output logic             main_source_select,
  output logic [1:0]       fast_rc_freq_sel,
  output logic [7:0]       pll_a_input_ratio,
  output logic [10:0]      pll_a_feedback_factor,
  output logic             pll_a_on,
  output logic             usb_pll_on,
  output clk_ctrl_pkg::master_src_t master_source_sel,
  output logic [2:0]       master_scaler,
  output logic             pll_a_half_select,
  output logic             cpu_clock_en,
  output logic             irq
);
  import clk_ctrl_pkg::*;

  parameter int FREQ_W = 16;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for asynchronous levels
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  wire  [5:0] async_in = {wait_mode, crystal_stable, fast_rc_stable,
                          main_clock_signal, slow_clock_signal, 1'b0};
  always_ff @(posedge clk) begin
    sync1_q <= async_in;
    sync2_q <= sync1_q;
  end
  wire slow_s = sync2_q[1];
  wire main_s = sync2_q[2];
  wire rc_st  = sync2_q[3];
  wire xt_st  = sync2_q[4];
  wire wait_s = sync2_q[5];

  logic slow_d1_q;
  logic main_d1_q;
  always_ff @(posedge clk) begin
    slow_d1_q <= slow_s;
    main_d1_q <= main_s;
  end
  wire slow_rise = slow_s & ~slow_d1_q;
  wire slow_fall = ~slow_s & slow_d1_q;
  wire main_rise = main_s & ~main_d1_q;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, one write and one read at a time
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) aw_hold_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
      end else if (wr_go) w_hold_q <= 1'b0;
      if (wr_go) s_axi_bvalid <= 1'b1;
      else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = ~aw_hold_q;
  assign s_axi_wready  = ~w_hold_q;
  assign s_axi_bresp   = 2'b00;

  // Decode helper reused by write strobes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction : hit
  wire wr_mor  = wr_go & hit(awaddr_q, `OFS_MAIN_OSC);
  wire wr_pll  = wr_go & hit(awaddr_q, `OFS_PLL_A);
  wire wr_usb  = wr_go & hit(awaddr_q, `OFS_USB_PLL);
  wire wr_mck  = wr_go & hit(awaddr_q, `OFS_MASTER_CLK);
  wire wr_imr  = wr_go & hit(awaddr_q, `OFS_INT_MASK);
  wire wr_fsm  = wr_go & hit(awaddr_q, `OFS_FAST_WAKE);

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic        sel_q;
  logic [1:0]  rcf_q;
  logic [7:0]  div_q;
  logic [7:0]  pcnt_q;
  logic [10:0] mul_q;
  logic        upll_en_q;
  logic [7:0]  ucnt_q;
  logic [1:0]  css_q;
  logic [2:0]  master_scaler_q;
  logic        half_q;
  logic [3:0]  imr_q;
  logic        lpm_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
      rcf_q <= 2'b00;
      div_q <= 8'h00;
      pcnt_q <= 8'h00;
      mul_q <= 11'h0;
      upll_en_q <= 1'b0;
      ucnt_q <= 8'h00;
      css_q <= 2'b01;
      master_scaler_q <= 3'b000;
      half_q <= 1'b0;
      imr_q <= 4'h0;
      lpm_q <= 1'b0;
    end else begin
      if (wait_s) sel_q <= 1'b0;
      else if (wr_mor) sel_q <= wdata_q[`MOR_SEL_BIT];
      if (wr_mor) rcf_q <= wdata_q[`MOR_RCF_LSB +: 2];
      if (wr_pll) begin
        div_q  <= wdata_q[`PLL_DIV_LSB +: 8];
        pcnt_q <= wdata_q[`PLL_CNT_LSB +: 8];
        mul_q  <= wdata_q[`PLL_MUL_LSB +: 11];
      end
      if (wr_usb) begin
        upll_en_q <= wdata_q[0];
        ucnt_q    <= wdata_q[`PLL_CNT_LSB +: 8];
      end
      if (wr_mck) begin
        css_q  <= wdata_q[`MCK_CSS_LSB +: 2];
        master_scaler_q <= wdata_q[`MCK_MASTER_SCALER_LSB +: 3];
        half_q <= wdata_q[`MCK_HALF_BIT];
      end
      if (wr_imr) imr_q <= wdata_q[3:0];
      if (wr_fsm) lpm_q <= wdata_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // switch done after source settles
  logic sel_out_q;
  logic swdone_q;
  wire  sel_chg = (sel_q != sel_out_q);
  wire  new_stable = sel_q ? xt_st : rc_st;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_out_q <= 1'b0;
      swdone_q  <= 1'b1;
    end else if (sel_chg) begin
      // Hold until target is stable to avoid a runt clock
      swdone_q <= 1'b0;
      if (new_stable) sel_out_q <= sel_q;
    end else begin
      swdone_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frequency counter restart events
  logic        stable_d_q;
  logic        sel_out_d_q;
  freq_state_t fc_q;
  logic [4:0]  falls_q;
  logic [FREQ_W-1:0] fcount_q;
  logic        frdy_q;
  wire fc_evt = (new_stable & ~stable_d_q & ~sel_chg)
              | (sel_out_q != sel_out_d_q);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stable_d_q <= 1'b0;
      sel_out_d_q <= 1'b0;
      fc_q <= FC_IDLE;
      falls_q <= 5'd0;
      fcount_q <= '0;
      frdy_q <= 1'b0;
    end else begin
      stable_d_q <= new_stable;
      sel_out_d_q <= sel_out_q;
      if (fc_evt) begin
        fc_q <= FC_ARM;
        frdy_q <= 1'b0;
      end else begin
        case (fc_q)
          FC_ARM: if (slow_rise) begin
            fc_q <= FC_RUN;
            fcount_q <= '0;
            falls_q <= 5'd0;
          end
          FC_RUN: begin
            if (main_rise) fcount_q <= fcount_q + 1'b1;
            if (slow_fall) falls_q <= falls_q + 5'd1;
            if (slow_fall && falls_q == `FREQ_GATE_PER - 5'd1) begin
              fc_q <= FC_DONE;
              frdy_q <= 1'b1;
            end
          end
          FC_IDLE, FC_DONE: fc_q <= fc_q;
          default: fc_q <= FC_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PLL settle counter
  logic [7:0] pll_cnt_q;
  logic       pll_lock_q;
  logic       pll_busy_q;
  wire pll_en = (mul_q != 11'h0) & (div_q != 8'h00);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_cnt_q <= 8'h00;
      pll_lock_q <= 1'b0;
      pll_busy_q <= 1'b0;
    end else if (wr_pll) begin
      pll_lock_q <= 1'b0;
      pll_busy_q <= 1'b1;
      pll_cnt_q  <= wdata_q[`PLL_CNT_LSB +: 8];
    end else if (pll_busy_q && pll_en) begin
      if (pll_cnt_q == 8'h00) begin
        pll_lock_q <= 1'b1;
        pll_busy_q <= 1'b0;
      end else if (slow_rise) pll_cnt_q <= pll_cnt_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // USB settle at slow/8
  logic [2:0] upre_q;
  logic [7:0] ucnt_run_q;
  logic       ulock_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upre_q <= 3'd0;
      ucnt_run_q <= 8'h00;
      ulock_q <= 1'b0;
    end else if (wr_usb) begin
      upre_q <= 3'd0;
      ucnt_run_q <= wdata_q[`PLL_CNT_LSB +: 8];
      ulock_q <= 1'b0;
    end else if (upll_en_q && !ulock_q) begin
      if (ucnt_run_q == 8'h00) ulock_q <= 1'b1;
      else if (slow_rise) begin
        upre_q <= upre_q + 3'd1;
        if (upre_q == `USB_SLOW_DIV) ucnt_run_q <= ucnt_run_q - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // master clock settle: wait one slow edge
  logic mck_rdy_q;
  always_ff @(posedge clk) begin
    if (!rst_n) mck_rdy_q <= 1'b1;
    else if (wr_mck) mck_rdy_q <= 1'b0;
    else if (slow_rise) mck_rdy_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // sleep on wait instruction
  logic sleep_pend_q;
  logic cpu_en_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_pend_q <= 1'b0;
      cpu_en_q <= 1'b1;
    end else if (wake_irq) begin
      sleep_pend_q <= 1'b0;
      cpu_en_q <= 1'b1;
    end else if (wait_instr && !lpm_q && cpu_en_q) begin
      sleep_pend_q <= 1'b1;
    end else if (sleep_pend_q && instr_done) begin
      // stop after instruction; bus side unaffected
      sleep_pend_q <= 1'b0;
      cpu_en_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status, interrupt and outputs
  wire [3:0] flags = {mck_rdy_q, ulock_q, pll_lock_q, swdone_q};
  wire [31:0] status = {24'h0, ~cpu_en_q, xt_st, rc_st, frdy_q, flags};
  logic irq_q;
  always_ff @(posedge clk) begin
    if (!rst_n) irq_q <= 1'b0;
    else irq_q <= |(flags & imr_q);
  end

  // Read mux
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    case (s_axi_araddr[7:2])
      6'h00: rmux = {29'h0, rcf_q, sel_q};
      6'h01: rmux = {15'h0, frdy_q, fcount_q};
      6'h02: rmux = {5'h0, mul_q, pcnt_q, div_q};
      6'h03: rmux = {16'h0, ucnt_q, 7'h0, upll_en_q};
      6'h04: rmux = {19'h0, half_q, 5'h0, master_scaler_q, 2'h0, css_q};
      6'h05: rmux = status;
      6'h06: rmux = {28'h0, imr_q};
      6'h07: rmux = {31'h0, lpm_q};
      default: rmux = 32'h0;
    endcase
  end
  wire rd_ok = s_axi_araddr[7:2] <= 6'h07;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rmux;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = ~s_axi_rvalid;

  // Registered control outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_source_select <= 1'b0;
      fast_rc_freq_sel <= 2'b00;
      pll_a_input_ratio <= 8'h00;
      pll_a_feedback_factor <= 11'h0;
      pll_a_on <= 1'b0;
      usb_pll_on <= 1'b0;
      master_source_sel <= SRC_MAIN;
      master_scaler <= 3'b000;
      pll_a_half_select <= 1'b0;
      cpu_clock_en <= 1'b1;
      irq <= 1'b0;
    end else begin
      main_source_select <= sel_out_q;
      fast_rc_freq_sel <= rcf_q;
      pll_a_input_ratio <= div_q;
      pll_a_feedback_factor <= mul_q;
      pll_a_on <= pll_en;
      usb_pll_on <= upll_en_q;
      master_source_sel <= master_src_t'(css_q);
      master_scaler <= master_scaler_q;
      pll_a_half_select <= half_q;
      cpu_clock_en <= cpu_en_q;
      irq <= irq_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_mck_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_mck |=> !mck_rdy_q) else $error("mck flag not cleared");
  a_pll_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pll |=> !pll_lock_q) else $error("pll flag not cleared");
  a_usb_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_usb |=> !ulock_q) else $error("usb flag not cleared");
  a_wait_rc: assert property (@(posedge clk) disable iff (!rst_n)
    wait_s |=> !sel_q) else $error("wait did not force rc");
  a_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
    (imr_q == 4'h0) |=> ##1 !irq) else $error("irq while masked");
  a_sleep_lpm: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(cpu_en_q) |-> $past(sleep_pend_q) && !lpm_q)
    else $error("bad sleep entry");
  a_wake_irq: assert property (@(posedge clk) disable iff (!rst_n)
    wake_irq |=> cpu_en_q) else $error("no wake on irq");
  a_freq_rdy: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(frdy_q) |-> $past(slow_fall) && $past(falls_q) == 5'd15)
    else $error("ready not on 16th fall");
  c_sleep: cover property (@(posedge clk) $fell(cpu_en_q));
  c_lock: cover property (@(posedge clk) $rose(pll_lock_q));
  c_freq: cover property (@(posedge clk) $rose(frdy_q));
endmodule : main_pll_master_clock_ctrl

/* File: test/osc_cpu_model.sv */
// Oscillator and processor stand-in facing the clock controller
`timescale 1ns/1ns
module osc_cpu_model #(
  parameter int SLOW_P = 40,
  parameter int MAIN_P = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench request and controller answer
  input  wire logic wfi_go,
  input  wire logic cpu_clock_en,
  // Oscillator levels
  output logic      slow_clock_signal,
  output logic      main_clock_signal,
  output logic      fast_rc_stable,
  output logic      crystal_stable,
  // Processor handshake
  output logic      wait_instr = 1'b0,
  output logic      instr_done = 1'b0
);
  int cnt_q = 0;
  //////////////////////////////////////////////////////////////////////////
  // Scaled oscillators; far slower than clk so edge detection can follow
  // crystal stand-in
  assign slow_clock_signal = (cnt_q % SLOW_P) < (SLOW_P / 2);
  assign main_clock_signal = (cnt_q % MAIN_P) < (MAIN_P / 2);
  assign fast_rc_stable    = cnt_q > 60;
  assign crystal_stable    = cnt_q > 120;
  //////////////////////////////////////////////////////////////////////////
  // Instruction only completes while the core still has its clock
  always_ff @(posedge clk) begin
    cnt_q      <= cnt_q + 1;
    wait_instr <= rst_n && wfi_go;
    instr_done <= rst_n && wait_instr && cpu_clock_en;
  end
endmodule : osc_cpu_model

/* File: test/tb_main_pll_master_clock_ctrl.sv */
// Self-checking bench for the clock controller
`timescale 1ns/1ns
`include "clk_ctrl_defs.svh"
module tb_main_pll_master_clock_ctrl;
  import clk_ctrl_pkg::*;
  localparam int SLOW_P = 40;
  localparam int MAIN_P = 8;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1, wait_mode = 1'b0;
  logic        wake_irq = 1'b0, wfi_go = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, slow_clock_signal, main_clock_signal;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fast_rc_freq_sel, rr, rb;
  logic        fast_rc_stable, crystal_stable, wait_instr, instr_done;
  logic        main_source_select, pll_a_on, usb_pll_on, irq;
  logic        pll_a_half_select, cpu_clock_en;
  logic [7:0]  pll_a_input_ratio;
  logic [10:0] pll_a_feedback_factor;
  logic [2:0]  master_scaler;
  master_src_t master_source_sel;
  int          err_total = 0, compares = 0, cyc = 0, t0, r, f;
  int unsigned shadow [8];
  logic [31:0] d;

  main_pll_master_clock_ctrl dut_u (.clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .slow_clock_signal, .main_clock_signal, .fast_rc_stable,
    .crystal_stable, .wait_mode, .wait_instr, .instr_done, .wake_irq,
    .main_source_select, .fast_rc_freq_sel, .pll_a_input_ratio,
    .pll_a_feedback_factor, .pll_a_on, .usb_pll_on, .master_source_sel,
    .master_scaler, .pll_a_half_select, .cpu_clock_en, .irq);
  osc_cpu_model #(.SLOW_P(SLOW_P), .MAIN_P(MAIN_P)) osc_u (.clk, .rst_n,
    .wfi_go, .cpu_clock_en, .slow_clock_signal, .main_clock_signal,
    .fast_rc_stable, .crystal_stable, .wait_instr, .instr_done);
  //////////////////////////////////////////////////////////////////////////
  // Clock and cycle count
  initial forever #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  //////////////////////////////////////////////////////////////////////////
  // Bus master tasks; ready lines are combinational so sample at the edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge clk);
      if (aw_p && s_axi_awready === 1'b1) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rb = s_axi_bresp;
    if (a < 8'h20) shadow[a[4:2]] = v;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : axi_rd
  //////////////////////////////////////////////////////////////////////////
  // Comparisons against the bench model
  task automatic check_val(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : check_val
  task automatic check_near(input string nm, input logic [31:0] e,
                            input logic [31:0] g, input int tol);
    compares++;
    if ($isunknown(g) || g + tol < e || g > e + tol) begin
      err_total++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask : check_near
  // Read back a register against the shadow copy
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] m);
    axi_rd(a);
    check_val("readback", shadow[a[4:2]] & m, rd & m);
  endtask : reg_chk
  // Poll a flag; the watchdog bounds a flag that never comes
  task automatic wait_bit(input logic [7:0] a, input int b);
    do axi_rd(a); while (rd[b] !== 1'b1);
  endtask : wait_bit
  // Outputs trail internal state by a cycle
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle
  // Start writes just after a slow fall, far from the next slow rise
  task automatic after_fall();
    @(negedge slow_clock_signal);
    @(posedge clk);
  endtask : after_fall
  task automatic wfi_pulse();
    wfi_go <= 1'b1;
    @(posedge clk);
    wfi_go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : wfi_pulse
  task automatic summarize();
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake or flag
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h5da48946));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_val("cpu_en", 1, cpu_clock_en);
    check_val("msrc", SRC_MAIN, 32'(master_source_sel));
    check_val("ratio", 0, pll_a_input_ratio);
    check_val("pll_on", 0, pll_a_on);
    check_val("sel", 0, main_source_select);
    axi_rd(`OFS_PLL_A);
    check_val("pll_reg", 0, rd);
    axi_rd(`OFS_STATUS);
    check_val("status", 32'h9, rd & 32'hf);
    wait_bit(`OFS_MAIN_FREQ, `MCFR_RDY_BIT);
    // Window runs from a slow rise to the sixteenth slow fall
    check_near("count", (31 * SLOW_P / 2) / MAIN_P, rd[15:0], 2);
    // Master clock on main, so the select may change
    t0 = cyc;
    axi_wr(`OFS_MAIN_OSC, 32'h5);
    wait_bit(`OFS_STATUS, `ST_SWITCH_DONE);
    check_val("sel", 1, main_source_select);
    check_val("rcf", 2, fast_rc_freq_sel);
    reg_chk(`OFS_MAIN_OSC, 32'h7);
    wait_bit(`OFS_MAIN_FREQ, `MCFR_RDY_BIT);
    check_near("gate", 33 * SLOW_P / 2, cyc - t0, SLOW_P);
    check_near("count", (31 * SLOW_P / 2) / MAIN_P, rd[15:0], 2);
    wait_mode <= 1'b1;
    repeat (8) @(posedge clk);
    check_val("sel_wait", 0, main_source_select);
    wait_mode <= 1'b0;
    // Random divider and feedback, lock timed in slow periods
    repeat (2) begin
      r = ($urandom % 255) + 1;
      f = ($urandom % 2047) + 1;
      d = (f << 16) | (3 << 8) | r;
      after_fall();
      t0 = cyc;
      axi_wr(`OFS_PLL_A, d);
      axi_rd(`OFS_STATUS);
      check_val("lock_clr", 0, rd[`ST_PLL_A]);
      check_val("ratio", r, pll_a_input_ratio);
      check_val("factor", f, pll_a_feedback_factor);
      check_val("pll_on", 1, pll_a_on);
      wait_bit(`OFS_STATUS, `ST_PLL_A);
      check_near("lock_t", 3 * SLOW_P, cyc - t0, SLOW_P);
      reg_chk(`OFS_PLL_A, 32'h07ffffff);
    end
    axi_wr(`OFS_PLL_A, r);
    settle();
    check_val("pll_off", 0, pll_a_on);
    axi_wr(`OFS_PLL_A, f << 16);
    settle();
    check_val("div_zero", 0, pll_a_on);
    // USB settle counts at slow divided by eight
    t0 = cyc;
    axi_wr(`OFS_USB_PLL, 32'h0201);
    axi_rd(`OFS_STATUS);
    check_val("ulock_clr", 0, rd[`ST_USB_PLL]);
    check_val("usb_on", 1, usb_pll_on);
    wait_bit(`OFS_STATUS, `ST_USB_PLL);
    check_near("ulock_t", 16 * SLOW_P, cyc - t0, 8 * SLOW_P);
    // Every scaler code, each source, half select both ways
    for (int p = 0; p < 8; p++) begin
      d = ((p & 1) << 12) | (p << 4) | (p & 3);
      after_fall();
      axi_wr(`OFS_MASTER_CLK, d);
      axi_rd(`OFS_STATUS);
      check_val("mck_clr", 0, rd[`ST_MCK]);
      check_val("msrc", p & 3, 32'(master_source_sel));
      check_val("scaler", p, master_scaler);
      check_val("half", p & 1, pll_a_half_select);
      wait_bit(`OFS_STATUS, `ST_MCK);
      reg_chk(`OFS_MASTER_CLK, 32'h1073);
    end
    // Set flags (switch, usb, mck) reach irq through their mask bit;
    // PLL settled stays clear while the PLL is off, so its mask gives 0
    for (int m = 0; m < 5; m++) begin
      d = (m < 3) ? (1 << (m + (m > 0))) : (m == 3) ? 2 : 0;
      axi_wr(`OFS_INT_MASK, d);
      settle();
      check_val("irq", m < 3, irq);
    end
    reg_chk(`OFS_INT_MASK, 32'hf);
    // Low power set: wait instruction must not gate the core
    axi_wr(`OFS_FAST_WAKE, 32'h1);
    wfi_pulse();
    check_val("cpu_lp", 1, cpu_clock_en);
    axi_wr(`OFS_FAST_WAKE, 32'h0);
    wfi_pulse();
    check_val("cpu_slp", 0, cpu_clock_en);
    axi_rd(`OFS_STATUS);
    check_val("sleeping", 1, rd[`ST_SLEEP]);
    wake_irq <= 1'b1;
    settle();
    check_val("cpu_wake", 1, cpu_clock_en);
    wake_irq <= 1'b0;
    // Unmapped write is ignored but still answered OKAY
    axi_wr(8'h3c, 32'h0);
    check_val("bresp", 2'b00, rb);
    axi_rd(8'h3c);
    check_val("rresp", 2'b10, rr);
    check_val("rdata", 0, rd);
    summarize();
  end
endmodule : tb_main_pll_master_clock_ctrl
